// ==== paod_pkg.sv ====
package paod_pkg;

  // Instruction word layout.
  localparam int INSTR_W = 24;
  localparam int OPC_MSB = 7;
  localparam int MOVE_MSB = 23;
  localparam int MOVE_LSB = 8;
  localparam int MOVE_W = 16;
  localparam int EXT_W = 24;
  localparam int CLASS_BIT = 7;
  localparam int DEST_BIT = 3;
  localparam int K2_BIT = 2;
  localparam int K1_BIT = 1;
  localparam int K0_BIT = 0;

  // Special opcode values.
  localparam logic [7:0] OPC_PURE_MOVE = 8'h00;
  localparam logic [7:0] OPC_RESERVED_MOVE = 8'h08;

  // Reset value for the operation output; the decoder registers nothing and no module reads it.
  localparam logic [3:0] RST_OPERATION = 4'h0;

  // Multiplier / ALU source operand codes.
  typedef enum logic [3:0] {
    PAOD_SRC_NONE = 4'h0,
    PAOD_SRC_X_LOW = 4'h1,
    PAOD_SRC_X_HIGH = 4'h2,
    PAOD_SRC_Y_LOW = 4'h3,
    PAOD_SRC_Y_HIGH = 4'h4,
    PAOD_SRC_X_PAIR = 4'h5,
    PAOD_SRC_Y_PAIR = 4'h6,
    PAOD_SRC_ACC_A = 4'h7,
    PAOD_SRC_ACC_B = 4'h8
  } paod_src_e;

  // ALU operation codes.
  typedef enum logic [4:0] {
    PAOD_OP_NONE = 5'h00,
    PAOD_OP_MOVE = 5'h01,
    PAOD_OP_MULTIPLY = 5'h02,
    PAOD_OP_TRANSFER = 5'h03,
    PAOD_OP_ADD_SHR = 5'h04,
    PAOD_OP_TEST = 5'h05,
    PAOD_OP_CMP = 5'h06,
    PAOD_OP_SUB_SHR = 5'h07,
    PAOD_OP_CMP_MAG = 5'h08,
    PAOD_OP_ADD = 5'h09,
    PAOD_OP_ROUND = 5'h0a,
    PAOD_OP_ADD_SHL = 5'h0b,
    PAOD_OP_ZERO = 5'h0c,
    PAOD_OP_SUB = 5'h0d,
    PAOD_OP_SUB_SHL = 5'h0e,
    PAOD_OP_NOT = 5'h0f,
    PAOD_OP_OR = 5'h10,
    PAOD_OP_XOR = 5'h11,
    PAOD_OP_AND = 5'h12,
    PAOD_OP_ADC = 5'h13,
    PAOD_OP_SBC = 5'h14,
    PAOD_OP_ASR = 5'h15,
    PAOD_OP_LSR = 5'h16,
    PAOD_OP_MAG = 5'h17,
    PAOD_OP_ROR = 5'h18,
    PAOD_OP_ASL = 5'h19,
    PAOD_OP_LSL = 5'h1a,
    PAOD_OP_NEG = 5'h1b,
    PAOD_OP_ROL = 5'h1c
  } paod_op_e;

endpackage

// ==== paod_mul_source.sv ====
`timescale 1ns/1ps
// Maps the three-bit multiplier source field onto the operand pair.
module paod_mul_source
  import paod_pkg::*;
(
  input wire logic [2:0] sourceField,
  output paod_src_e firstSource,
  output paod_src_e secondSource
);

  always_comb begin
    case (sourceField)
      3'h0: begin
        firstSource = PAOD_SRC_X_LOW;
        secondSource = PAOD_SRC_X_LOW;
      end
      3'h1: begin
        firstSource = PAOD_SRC_Y_LOW;
        secondSource = PAOD_SRC_Y_LOW;
      end
      3'h2: begin
        firstSource = PAOD_SRC_X_HIGH;
        secondSource = PAOD_SRC_X_LOW;
      end
      3'h3: begin
        firstSource = PAOD_SRC_Y_HIGH;
        secondSource = PAOD_SRC_Y_LOW;
      end
      3'h4: begin
        firstSource = PAOD_SRC_X_LOW;
        secondSource = PAOD_SRC_Y_HIGH;
      end
      3'h5: begin
        firstSource = PAOD_SRC_Y_LOW;
        secondSource = PAOD_SRC_X_LOW;
      end
      3'h6: begin
        firstSource = PAOD_SRC_X_HIGH;
        secondSource = PAOD_SRC_Y_LOW;
      end
      default: begin
        firstSource = PAOD_SRC_Y_HIGH;
        secondSource = PAOD_SRC_X_HIGH;
      end
    endcase
  end

endmodule

// ==== paod_decoder.sv ====
`timescale 1ns/1ps
module paod_decoder
  import paod_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [INSTR_W-1:0] instrWord,
  input wire logic [EXT_W-1:0] extensionWord,
  output logic [MOVE_W-1:0] moveField,
  output logic [EXT_W-1:0] moveExtension,
  output logic isMultiply,
  output paod_src_e firstSource,
  output paod_src_e secondSource,
  output logic destAccB,
  output logic negateProduct,
  output logic accumulate,
  output logic roundResult,
  output paod_op_e operation,
  output logic moveOnly,
  output logic reservedCode
);

  // The clock and reset only exist for the enclosing stage; nothing here is registered.
  // Folding them into one unread net keeps the ports without leaving an input floating.
  logic unusedClockPins;
  assign unusedClockPins = clk ^ resetn;

  // Opcode fields shared by both classes; the group field doubles as the multiplier source.
  logic [7:0] opcode;
  logic [2:0] groupField;
  logic [2:0] selectField;
  logic destBit;
  paod_src_e mulFirst;
  paod_src_e mulSecond;
  paod_src_e otherAcc;

  assign opcode = instrWord[OPC_MSB:0];
  assign groupField = opcode[6:4];
  assign selectField = opcode[2:0];
  assign destBit = opcode[DEST_BIT];

  // The move field is not decoded here; the move logic owns its meaning.
  // move field passthrough
  assign moveField = instrWord[MOVE_MSB:MOVE_LSB];
  assign moveExtension = extensionWord;

  paod_mul_source mulSourceUnit (
    .sourceField(groupField),
    .firstSource(mulFirst),
    .secondSource(mulSecond)
  );

  // Accumulator code for a destination bit; both classes share the one encoding.
  function automatic paod_src_e acc_of(input logic pickB);
    if (pickB) begin
      acc_of = PAOD_SRC_ACC_B;
    end else begin
      acc_of = PAOD_SRC_ACC_A;
    end
  endfunction

  assign otherAcc = acc_of(!destBit);

  // Zero-padded input register picked by groups 100..111.
  function automatic paod_src_e padded_source(input logic [1:0] sel);
    case (sel)
      2'h0: padded_source = PAOD_SRC_X_LOW;
      2'h1: padded_source = PAOD_SRC_Y_LOW;
      2'h2: padded_source = PAOD_SRC_X_HIGH;
      default: padded_source = PAOD_SRC_Y_HIGH;
    endcase
  endfunction

  // Every output gets a default first, so no path can infer a latch.
  // combinational decode
  always_comb begin
    isMultiply = 1'b0;
    firstSource = PAOD_SRC_NONE;
    secondSource = PAOD_SRC_NONE;
    destAccB = destBit;
    negateProduct = 1'b0;
    accumulate = 1'b0;
    roundResult = 1'b0;
    operation = PAOD_OP_NONE;
    moveOnly = 1'b0;
    reservedCode = 1'b0;
    // The multiply class ignores the group decode; its field feeds the pair table.
    // multiply class
    if (opcode[CLASS_BIT]) begin
      isMultiply = 1'b1;
      firstSource = mulFirst;
      secondSource = mulSecond;
      destAccB = destBit;
      negateProduct = opcode[K2_BIT];
      accumulate = opcode[K1_BIT];
      roundResult = opcode[K0_BIT];
      operation = PAOD_OP_MULTIPLY;
    end else begin
      // Everything else splits on the group field first, then on the select field.
      // non-multiply class
      case (groupField)
        3'h0: begin
          secondSource = otherAcc;
          case (selectField)
            3'h0: begin
              // Select 000 of group 000 is only a move when every other bit is clear too.
              // pure move and reserved
              if (opcode == OPC_PURE_MOVE) begin
                operation = PAOD_OP_MOVE;
                moveOnly = 1'b1;
                secondSource = PAOD_SRC_NONE;
              end else begin
                reservedCode = opcode == OPC_RESERVED_MOVE;
                secondSource = PAOD_SRC_NONE;
              end
            end
            3'h1: operation = PAOD_OP_TRANSFER;
            3'h2: operation = PAOD_OP_ADD_SHR;
            3'h3: begin
              operation = PAOD_OP_TEST;
              secondSource = PAOD_SRC_NONE;
            end
            3'h5: operation = PAOD_OP_CMP;
            3'h6: operation = PAOD_OP_SUB_SHR;
            3'h7: operation = PAOD_OP_CMP_MAG;
            default: begin
              // A reserved code must not reach the ALU, so it leaves every source empty.
              // reserved flagged
              reservedCode = 1'b1;
              secondSource = PAOD_SRC_NONE;
            end
          endcase
        end
        3'h1: begin
          secondSource = otherAcc;
          case (selectField)
            3'h0: operation = PAOD_OP_ADD;
            3'h1: operation = PAOD_OP_ROUND;
            3'h2: operation = PAOD_OP_ADD_SHL;
            3'h3: operation = PAOD_OP_ZERO;
            3'h4: operation = PAOD_OP_SUB;
            3'h6: operation = PAOD_OP_SUB_SHL;
            3'h7: operation = PAOD_OP_NOT;
            default: reservedCode = 1'b1;
          endcase
          // Round, clear and not work on the destination alone; the reserved slot has none.
          if (selectField == 3'h1 || selectField == 3'h3 || selectField == 3'h7 ||
              selectField == 3'h5) begin
            secondSource = PAOD_SRC_NONE;
          end
        end
        3'h2, 3'h3: begin
          // Bit 1 of the select qualifies the source: clear picks a register pair,
          // set picks the destination accumulator itself.
          if (!opcode[K1_BIT]) begin
            // Only 000, 001, 100 and 101 land here, so the default is the carry subtract.
            // register pair source
            secondSource = groupField[0] ? PAOD_SRC_Y_PAIR : PAOD_SRC_X_PAIR;
            case (selectField)
              3'h0: operation = PAOD_OP_ADD;
              3'h1: operation = PAOD_OP_ADC;
              3'h4: operation = PAOD_OP_SUB;
              default: operation = PAOD_OP_SBC;
            endcase
          end else begin
            // Only bits 2 and 0 of the select matter here; the group bit picks the direction.
            // accumulator shifts
            firstSource = acc_of(destBit);
            case ({groupField[0], selectField[2], selectField[0]})
              3'h0: operation = PAOD_OP_ASR;
              3'h1: operation = PAOD_OP_LSR;
              3'h2: operation = PAOD_OP_MAG;
              3'h3: operation = PAOD_OP_ROR;
              3'h4: operation = PAOD_OP_ASL;
              3'h5: operation = PAOD_OP_LSL;
              3'h6: operation = PAOD_OP_NEG;
              default: operation = PAOD_OP_ROL;
            endcase
          end
        end
        default: begin
          secondSource = padded_source(groupField[1:0]);
          case (selectField)
            3'h0: operation = PAOD_OP_ADD;
            3'h1: operation = PAOD_OP_TRANSFER;
            3'h2: operation = PAOD_OP_OR;
            3'h3: operation = PAOD_OP_XOR;
            3'h4: operation = PAOD_OP_SUB;
            3'h5: operation = PAOD_OP_CMP;
            3'h6: operation = PAOD_OP_AND;
            default: operation = PAOD_OP_CMP_MAG;
          endcase
        end
      endcase
    end
  end

endmodule

// ==== paod_decoder_properties.sv ====
`timescale 1ns/1ps
// Ties the class, destination, control, move and reserved outputs to the opcode bits that cause them; firstSource goes unchecked.
module paod_decoder_properties
  import paod_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [INSTR_W-1:0] instrWord,
  input wire logic [EXT_W-1:0] extensionWord,
  input wire logic [MOVE_W-1:0] moveField,
  input wire logic [EXT_W-1:0] moveExtension,
  input wire logic isMultiply,
  input wire paod_src_e firstSource,
  input wire paod_src_e secondSource,
  input wire logic destAccB,
  input wire logic negateProduct,
  input wire logic accumulate,
  input wire logic roundResult,
  input wire paod_op_e operation,
  input wire logic moveOnly,
  input wire logic reservedCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_CLASS: assert property (isMultiply == instrWord[7])
    else $error("class bit not followed");
  AST_DEST: assert property (destAccB == instrWord[3])
    else $error("destination bit not followed");
  AST_CTRL: assert property ({negateProduct, accumulate, roundResult} ==
    (instrWord[7] ? instrWord[2:0] : 3'h0)) else $error("control bits wrong");
  AST_MUL: assert property (isMultiply |-> operation == PAOD_OP_MULTIPLY)
    else $error("multiply operation wrong");
  AST_MOVE: assert property (moveField == instrWord[23:8]
    && moveExtension == extensionWord) else $error("move field not passed");
  AST_PURE: assert property (moveOnly == (instrWord[7:0] == OPC_PURE_MOVE))
    else $error("pure move flag wrong");
  AST_RSVD: assert property ((instrWord[7:0] == OPC_RESERVED_MOVE) |-> reservedCode)
    else $error("reserved move not flagged");
  AST_REFUSE: assert property (reservedCode |-> operation == PAOD_OP_NONE
    && secondSource == PAOD_SRC_NONE && !isMultiply) else $error("reserved code issued");
  AST_HOLD: assert property ($stable(instrWord) |-> $stable(operation)
    && $stable(secondSource)) else $error("decode moved on a held word");
  COV_MAC: cover property (isMultiply && accumulate);
  COV_RSV: cover property (reservedCode);
  COV_MOVE: cover property (moveOnly);
endmodule

// ==== paod_fetch_model.sv ====
`timescale 1ns/1ps
// Fetch stage ahead of the decoder: one register per word, as the pipeline has.
module paod_fetch_model
  import paod_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [INSTR_W-1:0] fetchWord,
  input wire logic [EXT_W-1:0] fetchExt,
  output logic [INSTR_W-1:0] instrWord,
  output logic [EXT_W-1:0] extensionWord
);
  // Reset loads a plain move so the decoder never sees an unknown word.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instrWord <= 24'h000000;
      extensionWord <= 24'h000000;
    end else begin
      instrWord <= fetchWord;
      extensionWord <= fetchExt;
    end
  end
endmodule

// ==== paod_decoder_tb.sv ====
`timescale 1ns/1ps
module paod_decoder_tb;
  import paod_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [23:0] fetchWord = 24'h000000;
  logic [23:0] fetchExt = 24'h000000;
  logic [23:0] instrWord;
  logic [23:0] extensionWord;
  logic [15:0] moveField;
  logic [23:0] moveExtension;
  logic isMultiply, destAccB, negateProduct, accumulate, roundResult, moveOnly, reservedCode;
  paod_src_e firstSource;
  paod_src_e secondSource;
  paod_op_e operation;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  paod_fetch_model u_paod_fetch_model (.clk(clk), .resetn(resetn), .fetchWord(fetchWord),
    .fetchExt(fetchExt), .instrWord(instrWord), .extensionWord(extensionWord));
  paod_decoder u_paod_decoder (.clk(clk), .resetn(resetn), .instrWord(instrWord),
    .extensionWord(extensionWord), .moveField(moveField), .moveExtension(moveExtension),
    .isMultiply(isMultiply), .firstSource(firstSource), .secondSource(secondSource),
    .destAccB(destAccB), .negateProduct(negateProduct), .accumulate(accumulate),
    .roundResult(roundResult), .operation(operation), .moveOnly(moveOnly),
    .reservedCode(reservedCode));
  // Free-running core clock.
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Sends one word through the fetch stage; move bits vary with the opcode.
  task automatic put(input logic [7:0] opc);
    logic [23:0] w;
    w = {opc ^ 8'h3c, ~opc, opc};
    @(posedge clk);
    fetchWord <= w;
    fetchExt <= ~w;
    @(posedge clk);
    #1;
    chk("moveField", moveField, w[23:8]);
    chk("moveExtension", moveExtension, 24'(~w));
  endtask
  task automatic t_mul;
    paod_src_e s1[8] = '{PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW, PAOD_SRC_X_HIGH, PAOD_SRC_Y_HIGH,
      PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW, PAOD_SRC_X_HIGH, PAOD_SRC_Y_HIGH};
    paod_src_e s2[8] = '{PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW, PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW,
      PAOD_SRC_Y_HIGH, PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW, PAOD_SRC_X_HIGH};
    for (int q = 0; q < 8; q++) begin
      put({1'b1, q[2:0], q[0], ~q[2:0]});
      chk("firstSource", firstSource, s1[q]);
      chk("secondSource", secondSource, s2[q]);
      chk("destAccB", destAccB, q[0]);
      chk("controls", {negateProduct, accumulate, roundResult}, 3'(~q[2:0]));
      chk("operation", operation, PAOD_OP_MULTIPLY);
      chk("isMultiply", isMultiply, 1'b1);
    end
  endtask
  // Walks one group with the destination at A; src NONE skips the source check.
  task automatic t_grp(input logic [2:0] g, input paod_op_e t[8], input paod_src_e src);
    for (int k = 0; k < 8; k++) begin
      put({1'b0, g, 1'b0, k[2:0]});
      chk("isMultiply", isMultiply, 1'b0);
      chk("operation", operation, t[k]);
      chk("reservedCode", reservedCode, t[k] == PAOD_OP_NONE);
      chk("controls", {negateProduct, accumulate, roundResult}, 3'h0);
      if (src != PAOD_SRC_NONE) chk("secondSource", secondSource, src);
    end
  endtask
  task automatic t_low;
    t_grp(3'h0, '{PAOD_OP_MOVE, PAOD_OP_TRANSFER, PAOD_OP_ADD_SHR, PAOD_OP_TEST, PAOD_OP_NONE,
      PAOD_OP_CMP, PAOD_OP_SUB_SHR, PAOD_OP_CMP_MAG}, PAOD_SRC_NONE);
    t_grp(3'h1, '{PAOD_OP_ADD, PAOD_OP_ROUND, PAOD_OP_ADD_SHL, PAOD_OP_ZERO, PAOD_OP_SUB,
      PAOD_OP_NONE, PAOD_OP_SUB_SHL, PAOD_OP_NOT}, PAOD_SRC_NONE);
    put(8'h08);
    chk("reservedCode", reservedCode, 1'b1);
    chk("moveOnly", moveOnly, 1'b0);
    put(8'h00);
    chk("moveOnly", moveOnly, 1'b1);
    put(8'h09);
    chk("secondSource", secondSource, PAOD_SRC_ACC_A);
    put(8'h01);
    chk("secondSource", secondSource, PAOD_SRC_ACC_B);
  endtask
  task automatic t_reg;
    paod_op_e t[8] = '{PAOD_OP_ADD, PAOD_OP_TRANSFER, PAOD_OP_OR, PAOD_OP_XOR, PAOD_OP_SUB,
      PAOD_OP_CMP, PAOD_OP_AND, PAOD_OP_CMP_MAG};
    paod_src_e s[4] = '{PAOD_SRC_X_LOW, PAOD_SRC_Y_LOW, PAOD_SRC_X_HIGH, PAOD_SRC_Y_HIGH};
    for (int g = 0; g < 4; g++) t_grp({1'b1, g[1:0]}, t, s[g]);
  endtask
  task automatic t_pair;
    paod_op_e p[4] = '{PAOD_OP_ADD, PAOD_OP_ADC, PAOD_OP_SUB, PAOD_OP_SBC};
    paod_op_e r[8] = '{PAOD_OP_ASR, PAOD_OP_LSR, PAOD_OP_MAG, PAOD_OP_ROR, PAOD_OP_ASL,
      PAOD_OP_LSL, PAOD_OP_NEG, PAOD_OP_ROL};
    for (int i = 0; i < 8; i++) begin
      put({3'h1, i[2], i[1], i[1], 1'b0, i[0]});
      chk("operation", operation, p[i[1:0]]);
      chk("secondSource", secondSource, i[2] ? PAOD_SRC_Y_PAIR : PAOD_SRC_X_PAIR);
      put({3'h1, i[2], i[0], i[1], 1'b1, i[0]});
      chk("operation", operation, r[i]);
      chk("firstSource", firstSource, i[0] ? PAOD_SRC_ACC_B : PAOD_SRC_ACC_A);
    end
  endtask
  // Cuts a hang short; the full run needs well under 400 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      close_out;
    end
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_mul;
    t_low;
    t_reg;
    t_pair;
    close_out;
  end
endmodule
bind paod_decoder paod_decoder_properties u_paod_decoder_properties (.clk(clk),
  .resetn(resetn), .instrWord(instrWord), .extensionWord(extensionWord),
  .moveField(moveField), .moveExtension(moveExtension), .isMultiply(isMultiply),
  .firstSource(firstSource), .secondSource(secondSource), .destAccB(destAccB),
  .negateProduct(negateProduct), .accumulate(accumulate), .roundResult(roundResult),
  .operation(operation), .moveOnly(moveOnly), .reservedCode(reservedCode));
